// ==== ctp_defines.vh ====
// register map, field positions and timing constants for the cascadable timer pair
// Notes on behaviour
// - joined pair runs while even run_enable set
// - independent odd timer runs on its run_enable
// - idle_halt set suspends counting during idle
// - gate bit used only with internal clock
// - prescale codes 00,01,10,11 give 1,8,64,256
// - pair_join set merges timers into 32 bits
// - pair_join clear gives two separate timers
// - even clock_source_select picks pin rising edge
// - odd clock_source_select picks own pin edge
// - odd control ignored while pair joined
// - unimplemented control bits read as zero
// - even counter low word, odd high word
// - even inputs drive pair, odd flag reports
// - odd period upper word, even period lower
`ifndef CTP_DEFINES_VH
`define CTP_DEFINES_VH
// word byte offsets
`define CTP_OFF_EVEN_CTRL 6'h00
`define CTP_OFF_ODD_CTRL 6'h04
`define CTP_OFF_EVEN_CNT 6'h08
`define CTP_OFF_ODD_CNT 6'h0C
`define CTP_OFF_EVEN_PER 6'h10
`define CTP_OFF_ODD_PER 6'h14
`define CTP_OFF_IRQ_STAT 6'h18
`define CTP_OFF_IRQ_MASK 6'h1C
`define CTP_OFF_IDLE 6'h20
// control fields
`define CTP_BIT_RUN 15
`define CTP_BIT_IDLE_HALT 13
`define CTP_BIT_GATE 6
`define CTP_BIT_PS_HI 5
`define CTP_BIT_PS_LO 4
`define CTP_BIT_JOIN 3
`define CTP_BIT_CS 1
// writable bits of each control register
`define CTP_EVEN_CTRL_MASK 16'hA07A
`define CTP_ODD_CTRL_MASK 16'hA072
// reset values
`define CTP_CTRL_RST 16'h0000
`define CTP_PER_RST 16'hFFFF
// interrupt status bits
`define CTP_IRQ_EVEN 0
`define CTP_IRQ_ODD 1
// internal clock is the system clock divided by two
`define CTP_INT_DIV 1'b1
`endif

// ==== ctp_sync.v ====
// two-flop synchroniser with rising and falling edge detect
`timescale 1ns/1ps
module ctp_sync (
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // raw pin
  input wire pin_i,
  // synchronised level and edges
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);
  reg meta_r; // first stage, read only by stage two
  reg sync_r; // second stage
  reg last_r; // delayed copy for edges

  // synchronise then delay once
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o = sync_r & ~last_r;
  assign fall_o = ~sync_r & last_r;
endmodule // ctp_sync

// ==== ctp_prescale.v ====
// prescaler: one tick per 1, 8, 64 or 256 input ticks
`timescale 1ns/1ps
`include "ctp_defines.vh"
module ctp_prescale (
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // control
  input wire clear_i,
  input wire [1:0] select_i,
  input wire tick_i,
  // divided tick
  output wire tick_o
);
  reg [7:0] cnt_r; // input tick counter
  reg [7:0] top;  // last count of a cycle

  // terminal count from prescale code
  always @* begin
    case (select_i)
      2'b00: top = 8'h00;
      2'b01: top = 8'h07;
      2'b10: top = 8'h3F;
      2'b11: top = 8'hFF;
      default: top = 8'h00;
    endcase
  end

  assign tick_o = tick_i & (cnt_r == top);

  // count input ticks, wrap at top
  always @(posedge clk_i) begin
    if (!resetn_i || clear_i) begin
      cnt_r <= 8'h00;
    end else if (tick_i) begin
      if (cnt_r == top) begin
        cnt_r <= 8'h00;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule // ctp_prescale

// ==== ctp_timer_pair.v ====
// cascadable pair of 16-bit timers with wishbone register access
`timescale 1ns/1ps
`include "ctp_defines.vh"
module ctp_timer_pair (
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire wb_err_o,
  // device state
  input wire idle_i,
  // external pins
  input wire even_ext_clock_pin_i,
  input wire even_gate_pin_i,
  input wire odd_ext_clock_pin_i,
  input wire odd_gate_pin_i,
  // interrupt
  output wire irq_o
);
  // control and data registers
  reg [15:0] even_ctrl_r; // even_timer_control
  reg [15:0] odd_ctrl_r; // odd_timer_control
  reg [15:0] even_cnt_r; // even counter, low word when joined
  reg [15:0] odd_cnt_r; // odd counter, high word when joined
  reg [15:0] even_per_r; // even_period_register
  reg [15:0] odd_per_r; // odd_period_register
  reg [1:0] irq_stat_r; // sticky flags
  reg [1:0] irq_mask_r; // enables
  reg sw_idle_r; // software idle request
  reg ack_r; // bus answer
  reg half_r; // internal clock divider
  reg [15:0] even_cnt_nxt;
  reg [15:0] odd_cnt_nxt;
  reg even_match;
  reg odd_match;

  // pin synchronisers
  wire eck_rise;
  wire ogt_fall;
  wire eg_lvl;
  wire oc_rise;
  wire og_lvl;
  wire eg_fall;

  ctp_sync u_eck (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(even_ext_clock_pin_i),
    .level_o(), .rise_o(eck_rise), .fall_o());
  ctp_sync u_egt (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(even_gate_pin_i),
    .level_o(eg_lvl), .rise_o(), .fall_o(eg_fall));
  ctp_sync u_ock (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(odd_ext_clock_pin_i),
    .level_o(), .rise_o(oc_rise), .fall_o());
  ctp_sync u_ogt (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(odd_gate_pin_i),
    .level_o(og_lvl), .rise_o(), .fall_o(ogt_fall));

  // idle is the pin or the software request
  wire idle = idle_i | sw_idle_r;
  wire pair_join = even_ctrl_r[`CTP_BIT_JOIN];

  // raw tick for one timer from its own control word
  function raw_tick;
    input [15:0] ctrl;
    input ext_rise;
    input gate_lvl;
    input half;
    input idl;
    begin
      if (!ctrl[`CTP_BIT_RUN]) begin
        raw_tick = 1'b0;
      end else if (ctrl[`CTP_BIT_IDLE_HALT] && idl) begin
        raw_tick = 1'b0;
      end else if (ctrl[`CTP_BIT_CS]) begin
        raw_tick = ext_rise; // gate ignored
      end else if (ctrl[`CTP_BIT_GATE]) begin
        raw_tick = half & gate_lvl;
      end else begin
        raw_tick = half;
      end
    end
  endfunction

  // even control also drives the joined pair
  wire even_raw = raw_tick(even_ctrl_r, eck_rise, eg_lvl, half_r, idle);
  // odd control ignored while joined
  wire odd_raw = pair_join ? 1'b0 : raw_tick(odd_ctrl_r, oc_rise, og_lvl, half_r, idle);

  wire even_tick;
  wire odd_tick;
  ctp_prescale u_pse (.clk_i(clk_i), .resetn_i(resetn_i),
    .clear_i(~even_ctrl_r[`CTP_BIT_RUN]), .select_i(even_ctrl_r[`CTP_BIT_PS_HI:`CTP_BIT_PS_LO]),
    .tick_i(even_raw), .tick_o(even_tick));
  ctp_prescale u_pso (.clk_i(clk_i), .resetn_i(resetn_i),
    .clear_i(~odd_ctrl_r[`CTP_BIT_RUN] | pair_join),
    .select_i(odd_ctrl_r[`CTP_BIT_PS_HI:`CTP_BIT_PS_LO]),
    .tick_i(odd_raw), .tick_o(odd_tick));

  // bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire bus_wr = bus_req & wb_we_i;
  wire bus_rd = bus_req & ~wb_we_i;
  reg mapped;
  always @* begin
    case (wb_adr_i)
      `CTP_OFF_EVEN_CTRL, `CTP_OFF_ODD_CTRL, `CTP_OFF_EVEN_CNT, `CTP_OFF_ODD_CNT,
      `CTP_OFF_EVEN_PER, `CTP_OFF_ODD_PER, `CTP_OFF_IRQ_STAT, `CTP_OFF_IRQ_MASK,
      `CTP_OFF_IDLE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign wb_ack_o = ack_r & mapped;
  assign wb_err_o = ack_r & ~mapped;
  wire lo_wr = bus_wr & wb_sel_i[0];
  wire hi_wr = bus_wr & wb_sel_i[1];

  // byte-lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] dat;
    input lo;
    input hi;
    begin
      merge16 = {hi ? dat[15:8] : old[15:8], lo ? dat[7:0] : old[7:0]};
    end
  endfunction

  // counter next values and period matches
  always @* begin
    even_cnt_nxt = even_cnt_r;
    odd_cnt_nxt = odd_cnt_r;
    even_match = 1'b0;
    odd_match = 1'b0;
    if (pair_join) begin
      if (even_tick) begin
        if ({odd_cnt_r, even_cnt_r} == {odd_per_r, even_per_r}) begin
          even_cnt_nxt = 16'h0000;
          odd_cnt_nxt = 16'h0000;
          odd_match = 1'b1;
        end else begin
          {odd_cnt_nxt, even_cnt_nxt} = {odd_cnt_r, even_cnt_r} + 32'h00000001;
        end
      end
    end else begin
      if (even_tick) begin
        if (even_cnt_r == even_per_r) begin
          even_cnt_nxt = 16'h0000;
          even_match = 1'b1;
        end else begin
          even_cnt_nxt = even_cnt_r + 16'h0001;
        end
      end
      if (odd_tick) begin
        if (odd_cnt_r == odd_per_r) begin
          odd_cnt_nxt = 16'h0000;
          odd_match = 1'b1;
        end else begin
          odd_cnt_nxt = odd_cnt_r + 16'h0001;
        end
      end
    end
  end

  // gated accumulation end also flags
  wire even_gate_evt = even_ctrl_r[`CTP_BIT_RUN] & even_ctrl_r[`CTP_BIT_GATE] &
    ~even_ctrl_r[`CTP_BIT_CS] & eg_fall;
  wire odd_gate_evt = ~pair_join & odd_ctrl_r[`CTP_BIT_RUN] & odd_ctrl_r[`CTP_BIT_GATE] &
    ~odd_ctrl_r[`CTP_BIT_CS] & ogt_fall;
  wire [1:0] evt = {odd_match | (pair_join & even_gate_evt) | odd_gate_evt,
    even_match | (~pair_join & even_gate_evt)};

  // registers, counters and flags
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      even_ctrl_r <= `CTP_CTRL_RST;
      odd_ctrl_r <= `CTP_CTRL_RST;
      even_cnt_r <= 16'h0000;
      odd_cnt_r <= 16'h0000;
      even_per_r <= `CTP_PER_RST;
      odd_per_r <= `CTP_PER_RST;
      irq_stat_r <= 2'b00;
      irq_mask_r <= 2'b00;
      sw_idle_r <= 1'b0;
      ack_r <= 1'b0;
      half_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
      half_r <= ~half_r;
      even_cnt_r <= even_cnt_nxt;
      odd_cnt_r <= odd_cnt_nxt;
      // read clears, new event wins
      if (bus_rd && wb_adr_i == `CTP_OFF_IRQ_STAT) begin
        irq_stat_r <= evt;
      end else begin
        irq_stat_r <= irq_stat_r | evt;
      end
      if (bus_wr) begin
        case (wb_adr_i)
          `CTP_OFF_EVEN_CTRL: even_ctrl_r <= merge16(even_ctrl_r, wb_dat_i[15:0], lo_wr,
            hi_wr) & `CTP_EVEN_CTRL_MASK;
          `CTP_OFF_ODD_CTRL: odd_ctrl_r <= merge16(odd_ctrl_r, wb_dat_i[15:0], lo_wr,
            hi_wr) & `CTP_ODD_CTRL_MASK;
          `CTP_OFF_EVEN_CNT: even_cnt_r <= merge16(even_cnt_r, wb_dat_i[15:0], lo_wr, hi_wr);
          `CTP_OFF_ODD_CNT: odd_cnt_r <= merge16(odd_cnt_r, wb_dat_i[15:0], lo_wr, hi_wr);
          `CTP_OFF_EVEN_PER: even_per_r <= merge16(even_per_r, wb_dat_i[15:0], lo_wr, hi_wr);
          `CTP_OFF_ODD_PER: odd_per_r <= merge16(odd_per_r, wb_dat_i[15:0], lo_wr, hi_wr);
          `CTP_OFF_IRQ_MASK: begin
            if (lo_wr) begin
              irq_mask_r <= wb_dat_i[1:0];
            end
          end
          `CTP_OFF_IDLE: begin
            if (lo_wr) begin
              sw_idle_r <= wb_dat_i[0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // registered read data
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_rd) begin
      case (wb_adr_i)
        `CTP_OFF_EVEN_CTRL: wb_dat_o <= {16'h0000, even_ctrl_r};
        `CTP_OFF_ODD_CTRL: wb_dat_o <= {16'h0000, odd_ctrl_r};
        `CTP_OFF_EVEN_CNT: wb_dat_o <= {16'h0000, even_cnt_r};
        `CTP_OFF_ODD_CNT: wb_dat_o <= {16'h0000, odd_cnt_r};
        `CTP_OFF_EVEN_PER: wb_dat_o <= {16'h0000, even_per_r};
        `CTP_OFF_ODD_PER: wb_dat_o <= {16'h0000, odd_per_r};
        `CTP_OFF_IRQ_STAT: wb_dat_o <= {30'h00000000, irq_stat_r};
        `CTP_OFF_IRQ_MASK: wb_dat_o <= {30'h00000000, irq_mask_r};
        `CTP_OFF_IDLE: wb_dat_o <= {31'h00000000, sw_idle_r};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // level interrupt from unmasked flags
  assign irq_o = |(irq_stat_r & irq_mask_r);
endmodule // ctp_timer_pair

// ==== ctp_pin_model.sv ====
// external clock and gate pin model for the timer pair
`timescale 1ns/1ps
module ctp_pin_model (
  // clock
  input wire clk_i,
  // pins, idle low between bursts
  output logic even_clk_o,
  output logic odd_clk_o,
  output logic even_gate_o,
  output logic odd_gate_o
);
  initial begin
    even_clk_o = 1'b0;
    odd_clk_o = 1'b0;
    even_gate_o = 1'b0;
    odd_gate_o = 1'b0;
  end
  // set one gate pin level just after an edge
  task automatic gate(input bit odd, input bit lvl);
    @(posedge clk_i);
    if (odd) odd_gate_o <= lvl; else even_gate_o <= lvl;
  endtask
  // n slow pulses, 3 cycles high and 4 low between pulses, so two-flop sync sees each
  task automatic pulse(input bit odd, input int n);
    repeat (n) begin
      @(posedge clk_i);
      if (odd) odd_clk_o <= 1'b1; else even_clk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      if (odd) odd_clk_o <= 1'b0; else even_clk_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
endmodule // ctp_pin_model

// ==== ctp_timer_pair_chk.sv ====
// bus and readback assertions for the timer pair
`timescale 1ns/1ps
module ctp_timer_pair_chk (
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire wb_err_o,
  // interrupt
  input wire irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // mapped word offsets and any answer
  wire map_w = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i <= 6'h20);
  wire ans_w = wb_ack_o || wb_err_o;
  sequence s_take; wb_cyc_i && wb_stb_i && !ans_w; endsequence
  sequence s_rd; wb_ack_o && !wb_we_i; endsequence
  chk_ack_mapped: assert property (s_take ##0 map_w |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acked");
  chk_err_unmapped: assert property (s_take ##0 !map_w |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  chk_answer_pulse: assert property (ans_w |=> !ans_w) else $error("answer too long");
  chk_answer_cause: assert property (ans_w |-> $past(wb_cyc_i && wb_stb_i))
    else $error("answer without request");
  chk_upper_zero: assert property (s_rd |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper half not zero");
  chk_even_unimpl: assert property (s_rd ##0 wb_adr_i == 6'h00 |-> (wb_dat_o[15:0] & 16'h5F85) == 16'h0000)
    else $error("even control reserved bit set");
  chk_odd_unimpl: assert property (s_rd ##0 wb_adr_i == 6'h04 |-> (wb_dat_o[15:0] & 16'h5F8D) == 16'h0000)
    else $error("odd control reserved bit set");
  chk_err_rdzero: assert property (wb_err_o && !wb_we_i |-> wb_dat_o == 32'h0000_0000)
    else $error("refused read not zero");
  chk_irq_reset: assert property ($rose(resetn_i) |-> !irq_o) else $error("irq after reset");
endmodule // ctp_timer_pair_chk
bind ctp_timer_pair ctp_timer_pair_chk chk_u (.clk_i(clk_i), .resetn_i(resetn_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irq_o(irq_o));

// ==== ctp_timer_pair_tb.sv ====
// self-checking bench for the timer pair
`timescale 1ns/1ps
module ctp_timer_pair_tb;
  logic clk_i = 1'b0, resetn_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, idle = 1'b0, lerr;
  logic [5:0] adr = 6'h00;
  logic [31:0] dat = 32'h0, rd, q;
  wire ack, err, irq, ec, oc, eg, og;
  int fail_count = 0, total_checks = 0;
  always #4 clk_i = ~clk_i;
  ctp_pin_model pin_u (.clk_i(clk_i), .even_clk_o(ec), .odd_clk_o(oc), .even_gate_o(eg),
    .odd_gate_o(og));
  ctp_timer_pair dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rd),
    .wb_ack_o(ack), .wb_err_o(err), .idle_i(idle), .even_ext_clock_pin_i(ec),
    .even_gate_pin_i(eg), .odd_ext_clock_pin_i(oc), .odd_gate_pin_i(og), .irq_o(irq));
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one classic cycle, held until ack or err is sampled
  task automatic wb(input logic w, input logic [5:0] a, input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {16'h0000, d};
    // look just after each edge; an answer seen here is sampled at the next edge
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    q = rd;
    lerr = err;
    @(posedge clk_i);
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
    if (n >= 50) begin
      fail_count++;
      end_of_test();
    end
  endtask
  task rc(input logic [5:0] a, input logic [31:0] e);
    wb(1'b0, a, 16'h0);
    cmp(q, e);
  endtask
  task t_regs;
    rc(6'h00, 32'h0); rc(6'h04, 32'h0); rc(6'h10, 32'hFFFF); rc(6'h1C, 32'h0);
    wb(1'b1, 6'h00, 16'hFFFF); rc(6'h00, 32'hA07A);
    wb(1'b1, 6'h04, 16'hFFFF); rc(6'h04, 32'hA072);
    wb(1'b1, 6'h00, 16'h0); wb(1'b1, 6'h04, 16'h0);
    rc(6'h24, 32'h0); cmp(lerr, 1'b1);
  endtask
  task t_prescale;
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, 6'h00, 16'h0); wb(1'b1, 6'h08, 16'h0);
      wb(1'b1, 6'h00, 16'h8002 | (k << 4));
      pin_u.pulse(0, 256);
      rc(6'h08, 32'd256 >> (k == 3 ? 8 : 3 * k));
    end
  endtask
  task t_odd;
    wb(1'b1, 6'h00, 16'h0); wb(1'b1, 6'h08, 16'h0); wb(1'b1, 6'h0C, 16'h0);
    wb(1'b1, 6'h04, 16'h8002);
    pin_u.pulse(1, 3); pin_u.pulse(0, 2);
    rc(6'h0C, 32'h3); rc(6'h08, 32'h0);
    wb(1'b1, 6'h04, 16'h0); pin_u.pulse(1, 2);
    rc(6'h0C, 32'h3);
  endtask
  task t_idle_gate;
    wb(1'b1, 6'h08, 16'h0); wb(1'b1, 6'h00, 16'hA002); idle <= 1'b1;
    pin_u.pulse(0, 3); rc(6'h08, 32'h0);
    wb(1'b1, 6'h00, 16'h8002); pin_u.pulse(0, 3); rc(6'h08, 32'h3);
    idle <= 1'b0;
    wb(1'b1, 6'h00, 16'h0); wb(1'b1, 6'h08, 16'h0); wb(1'b1, 6'h00, 16'h8040);
    repeat (40) @(posedge clk_i); rc(6'h08, 32'h0);
    pin_u.gate(0, 1'b1); repeat (20) @(posedge clk_i); pin_u.gate(0, 1'b0);
    repeat (6) @(posedge clk_i); rc(6'h18, 32'h1);
    wb(1'b1, 6'h08, 16'h0);
    wb(1'b1, 6'h00, 16'h8042); pin_u.pulse(0, 2); rc(6'h08, 32'h2);
  endtask
  task t_joined;
    wb(1'b1, 6'h00, 16'h0); wb(1'b1, 6'h04, 16'h0); wb(1'b1, 6'h08, 16'hFFFF);
    wb(1'b1, 6'h0C, 16'h0); wb(1'b1, 6'h00, 16'h800A);
    pin_u.pulse(1, 2); pin_u.pulse(0, 1);
    rc(6'h08, 32'h0); rc(6'h0C, 32'h1);
    wb(1'b1, 6'h00, 16'h0008); pin_u.pulse(0, 2); rc(6'h08, 32'h0);
    wb(1'b1, 6'h0C, 16'h0); wb(1'b1, 6'h10, 16'h4); wb(1'b1, 6'h14, 16'h0);
    wb(1'b1, 6'h00, 16'h800A); pin_u.pulse(0, 5);
    rc(6'h08, 32'h0); cmp(irq, 1'b0);
    wb(1'b1, 6'h1C, 16'h2); cmp(irq, 1'b1);
    rc(6'h18, 32'h2); cmp(irq, 1'b0);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    t_regs(); t_prescale(); t_odd(); t_idle_gate(); t_joined();
    end_of_test();
  end
endmodule // ctp_timer_pair_tb
